// ---- hw/ccm_call_mode_select.sv ----
// call-mode selection and call timing for the cpu core
// ==================================================
`default_nettype none
module ccm_call_mode_select
   import ccm_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // register access from the core
   input  wire logic                  bank_sel_we,
   input  wire logic [BANK_SEL_W-1:0] bank_sel_wdata,
   // instruction issue
   input  wire logic                  instr_valid,
   input  wire logic [2:0]            instr_op,
   // register and mode state
   output logic [BANK_SEL_W-1:0]      stack_bank_select,
   output logic                       legacy_call_mode,
   output logic                       extended_call_mode,
   // stack frame control
   output logic [1:0]                 frame_bytes,
   output logic                       push_frame,
   output logic                       pop_frame,
   // execution result
   output logic                       instr_illegal,
   output logic                       call_busy,
   output logic                       call_done,
   output logic [2:0]                 call_cycles
);
   // ==================================================
   // register state
   logic [BANK_SEL_W-1:0] bank_sel_ff;
   logic [BANK_SEL_W-1:0] nxt_bank_sel;
   logic                  leg_ff, nxt_leg;
   logic                  ext_ff, nxt_ext;
   logic [1:0]            frm_ff, nxt_frm;
   logic                  push_ff, nxt_push;
   logic                  pop_ff, nxt_pop;
   logic                  ill_ff, nxt_ill;
   logic                  busy_ff, nxt_busy;
   logic                  done_ff, nxt_done;
   logic [2:0]            cyc_ff, nxt_cyc;
   logic                  mode_leg;
   logic                  start;
   logic [2:0]            length;
   logic                  cc_busy;
   logic                  cc_last;
   ccm_op_e               op;

   assign op       = ccm_op_e'(instr_op);
   assign mode_leg = bank_sel_ff[MODE_BIT];

   // ==================================================
   // decode; a new instruction is ignored while a call runs
   always_comb begin
      start  = 1'b0;
      length = 3'h0;
      nxt_ill = 1'b0;
      nxt_push = 1'b0;
      nxt_pop  = 1'b0;
      if (instr_valid && !cc_busy) begin
         case (op)
            CCM_OP_ABS_CALL: begin
               start  = 1'b1;
               length = mode_leg ? ABS_CYC_LEGACY : ABS_CYC_EXT;
               nxt_push = 1'b1;
            end
            CCM_OP_FAST_CALL: begin
               start  = 1'b1;
               length = mode_leg ? FAST_CYC_LEGACY : FAST_CYC_EXT;
               nxt_push = 1'b1;
            end
            CCM_OP_FAR_CALL: begin
               nxt_ill  = mode_leg;
               nxt_push = !mode_leg;
            end
            CCM_OP_FAR_BRANCH: begin
               nxt_ill = mode_leg;
            end
            CCM_OP_RETURN: begin
               nxt_pop = 1'b1;
            end
            default: begin
               nxt_ill = 1'b0;
            end
         endcase
      end
   end

   ccm_cycle_count u_cnt (
      .clk    (clk),
      .resetn (resetn),
      .start  (start),
      .length (length),
      .busy   (cc_busy),
      .last   (cc_last)
   );

   // ==================================================
   // next values of the registered outputs
   always_comb begin
      // whole nibble in one write, no per-bit path
      nxt_bank_sel = bank_sel_we ? bank_sel_wdata : bank_sel_ff;
      nxt_leg  = nxt_bank_sel[MODE_BIT];
      nxt_ext  = !nxt_bank_sel[MODE_BIT];
      nxt_frm  = nxt_bank_sel[MODE_BIT] ? FRAME_LEGACY
                                        : FRAME_EXTENDED;
      nxt_busy = start || (cc_busy && !cc_last);
      nxt_done = cc_last || (start && length == 3'h1);
      nxt_cyc  = start ? length : cyc_ff;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bank_sel_ff <= BANK_SEL_RESET;
         leg_ff  <= 1'b1;
         ext_ff  <= 1'b0;
         frm_ff  <= FRAME_LEGACY;
         push_ff <= 1'b0;
         pop_ff  <= 1'b0;
         ill_ff  <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         cyc_ff  <= 3'h0;
      end else begin
         bank_sel_ff <= nxt_bank_sel;
         leg_ff  <= nxt_leg;
         ext_ff  <= nxt_ext;
         frm_ff  <= nxt_frm;
         push_ff <= nxt_push;
         pop_ff  <= nxt_pop;
         ill_ff  <= nxt_ill;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         cyc_ff  <= nxt_cyc;
      end
   end

   assign stack_bank_select  = bank_sel_ff;
   assign legacy_call_mode   = leg_ff;
   assign extended_call_mode = ext_ff;
   assign frame_bytes        = frm_ff;
   assign push_frame         = push_ff;
   assign pop_frame          = pop_ff;
   assign instr_illegal      = ill_ff;
   assign call_busy          = busy_ff;
   assign call_done          = done_ff;
   assign call_cycles        = cyc_ff;

   // ==================================================
   // checks
   chk_mode_follows_bit: assert property (
      @(posedge clk) disable iff (!resetn)
      legacy_call_mode == stack_bank_select[MODE_BIT]
      && extended_call_mode == !legacy_call_mode)
      else $error("mode output differs from mode bit");

   chk_frame_size: assert property (
      @(posedge clk) disable iff (!resetn)
      frame_bytes == (legacy_call_mode ? 2'h2 : 2'h3))
      else $error("wrong frame size for mode");

   chk_far_refused: assert property (
      @(posedge clk) disable iff (!resetn)
      (instr_valid && !cc_busy && mode_leg
       && (op == CCM_OP_FAR_CALL || op == CCM_OP_FAR_BRANCH))
      |=> instr_illegal && !push_frame)
      else $error("far instruction accepted in legacy mode");

   chk_far_allowed: assert property (
      @(posedge clk) disable iff (!resetn)
      (instr_valid && !cc_busy && !mode_leg && op == CCM_OP_FAR_CALL)
      |=> !instr_illegal && push_frame)
      else $error("far call refused in extended mode");

   chk_abs_legacy: assert property (
      @(posedge clk) disable iff (!resetn)
      (instr_valid && !cc_busy && mode_leg && op == CCM_OP_ABS_CALL)
      |=> call_busy [*2] ##1 call_done)
      else $error("absolute call not three cycles");

   chk_abs_ext: assert property (
      @(posedge clk) disable iff (!resetn)
      (instr_valid && !cc_busy && !mode_leg && op == CCM_OP_ABS_CALL)
      |=> call_busy [*3] ##1 call_done)
      else $error("absolute call not four cycles");

   chk_fast_cycles: assert property (
      @(posedge clk) disable iff (!resetn)
      (instr_valid && !cc_busy && op == CCM_OP_FAST_CALL)
      |=> call_cycles == ($past(mode_leg) ? FAST_CYC_LEGACY : FAST_CYC_EXT))
      else $error("fast call length wrong");

   chk_nibble_write: assert property (
      @(posedge clk) disable iff (!resetn)
      bank_sel_we |=> stack_bank_select == $past(bank_sel_wdata))
      else $error("register write lost");

   chk_reset_legacy: assert property (
      @(posedge clk) $rose(resetn) |-> legacy_call_mode)
      else $error("reset did not select legacy mode");

   chk_return_pops: assert property (
      @(posedge clk) disable iff (!resetn)
      (instr_valid && !cc_busy && op == CCM_OP_RETURN) |=> pop_frame)
      else $error("return did not pop");

   cov_abs_ext: cover property (@(posedge clk) disable iff (!resetn)
      call_done && call_cycles == 3'h4);
   cov_far_ok: cover property (@(posedge clk) disable iff (!resetn)
      push_frame && extended_call_mode);
   cov_far_bad: cover property (@(posedge clk) disable iff (!resetn)
      instr_illegal);
endmodule
`default_nettype wire

// ---- hw/ccm_pkg.sv ----
// constants for the call-mode select block
`default_nettype none
package ccm_pkg;
   // stack bank select register
   localparam int          BANK_SEL_W     = 4;
   localparam int          MODE_BIT       = 3;
   localparam logic [3:0]  BANK_SEL_RESET = 4'h8;
   // stack bytes per call frame
   localparam logic [1:0]  FRAME_LEGACY   = 2'h2;
   localparam logic [1:0]  FRAME_EXTENDED = 2'h3;
   // machine cycles of the call instructions
   localparam logic [2:0]  ABS_CYC_LEGACY  = 3'h3;
   localparam logic [2:0]  ABS_CYC_EXT     = 3'h4;
   localparam logic [2:0]  FAST_CYC_LEGACY = 3'h2;
   localparam logic [2:0]  FAST_CYC_EXT    = 3'h3;
   // instruction classes presented to the decoder
   typedef enum logic [2:0] {
      CCM_OP_NONE,
      CCM_OP_ABS_CALL,
      CCM_OP_FAST_CALL,
      CCM_OP_FAR_CALL,
      CCM_OP_FAR_BRANCH,
      CCM_OP_RETURN
   } ccm_op_e;
endpackage
`default_nettype wire

// ---- hw/ccm_cycle_count.sv ----
// machine-cycle counter for one call instruction
`default_nettype none
module ccm_cycle_count
   import ccm_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // control
   input  wire logic       start,
   input  wire logic [2:0] length,
   // status
   output logic            busy,
   output logic            last
);
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;

   // ==================================================
   // count down from one less than the instruction length
   always_comb begin
      nxt_cnt = cnt_ff;
      if (start) begin
         nxt_cnt = length - 3'h1;
      end else if (cnt_ff != 3'h0) begin
         nxt_cnt = cnt_ff - 3'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= 3'h0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign busy = (cnt_ff != 3'h0);
   assign last = (cnt_ff == 3'h1);
endmodule
`default_nettype wire

// ---- verification/ccm_call_mode_select_tb_top.sv ----
// self-checking bench for the call-mode select block
`default_nettype none
module ccm_call_mode_select_tb_top
   import ccm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ==================================================
   // stimulus and observed signals
   logic                  clk;
   logic                  resetn;
   logic                  bank_sel_we;
   logic [BANK_SEL_W-1:0] bank_sel_wdata;
   logic                  instr_valid;
   logic [2:0]            instr_op;
   logic [BANK_SEL_W-1:0] stack_bank_select;
   logic                  legacy_call_mode;
   logic                  extended_call_mode;
   logic [1:0]            frame_bytes;
   logic                  push_frame;
   logic                  pop_frame;
   logic                  instr_illegal;
   logic                  call_busy;
   logic                  call_done;
   logic [2:0]            call_cycles;
   int                    n_errors;
   int                    tests_run;

   ccm_call_mode_select i_ccm_call_mode_select (
      .clk                (clk),
      .resetn             (resetn),
      .bank_sel_we        (bank_sel_we),
      .bank_sel_wdata     (bank_sel_wdata),
      .instr_valid        (instr_valid),
      .instr_op           (instr_op),
      .stack_bank_select  (stack_bank_select),
      .legacy_call_mode   (legacy_call_mode),
      .extended_call_mode (extended_call_mode),
      .frame_bytes        (frame_bytes),
      .push_frame         (push_frame),
      .pop_frame          (pop_frame),
      .instr_illegal      (instr_illegal),
      .call_busy          (call_busy),
      .call_done          (call_done),
      .call_cycles        (call_cycles)
   );

   initial clk = 1'b0;
   always #25 clk = ~clk;

   // ==================================================
   // shared helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // whole nibble only; outputs settle one edge later
   task automatic wr(input logic [3:0] d);
      @(negedge clk);
      bank_sel_we    = 1'b1;
      bank_sel_wdata = d;
      @(negedge clk);
      bank_sel_we    = 1'b0;
      chk(8'(stack_bank_select), 8'(d));
      chk(8'(legacy_call_mode), 8'(d[3]));
      chk(8'(extended_call_mode), 8'(!d[3]));
      chk(8'(frame_bytes), 8'(d[3] ? FRAME_LEGACY : FRAME_EXTENDED));
   endtask

   // one-cycle issue; returns in the cycle the pulses stand
   task automatic issue(input logic [2:0] op);
      @(negedge clk);
      instr_valid = 1'b1;
      instr_op    = op;
      @(negedge clk);
      instr_valid = 1'b0;
      instr_op    = 3'h0;
   endtask

   // ==================================================
   // scenarios
   task automatic t_reset_state();
      chk(8'(stack_bank_select), 8'(BANK_SEL_RESET));
      chk(8'(extended_call_mode), 8'h00);
      chk(8'(legacy_call_mode), 8'h01);
      chk(8'(frame_bytes), 8'(FRAME_LEGACY));
   endtask

   task automatic t_reg_writes();
      logic [3:0] vals [5];
      vals = '{4'h0, 4'h8, 4'h7, 4'hf, 4'h8};
      foreach (vals[i]) wr(vals[i]);
   endtask

   task automatic t_call(input logic [3:0] m, input logic [2:0] op,
                         input logic [2:0] n_exp);
      int n;
      wr(m);
      issue(op);
      chk(8'(push_frame), 8'h01);
      chk(8'(call_cycles), 8'(n_exp));
      chk(8'(call_busy), 8'h01);
      // bounded wait; running out shows up as a count mismatch
      for (n = 1; n < 8 && call_done !== 1'b1; n++) @(negedge clk);
      chk(8'(n), 8'(n_exp));
      chk(8'(call_busy), 8'h00);
   endtask

   task automatic t_far();
      wr(4'h8);
      issue(3'(CCM_OP_FAR_CALL));
      chk({7'h0, instr_illegal}, 8'h01);
      chk({7'h0, push_frame}, 8'h00);
      issue(3'(CCM_OP_FAR_BRANCH));
      chk({7'h0, instr_illegal}, 8'h01);
      wr(4'h0);
      issue(3'(CCM_OP_FAR_BRANCH));
      chk({7'h0, instr_illegal}, 8'h00);
      issue(3'(CCM_OP_FAR_CALL));
      chk({7'h0, instr_illegal}, 8'h00);
      chk({7'h0, push_frame}, 8'h01);
   endtask

   task automatic t_return(input logic [3:0] m);
      wr(m);
      issue(3'(CCM_OP_RETURN));
      chk({7'h0, pop_frame}, 8'h01);
      chk(8'(frame_bytes), 8'(m[3] ? FRAME_LEGACY : FRAME_EXTENDED));
   endtask

   // reset in mid-call must restore legacy mode and stop the count
   task automatic t_mid_reset();
      wr(4'h0);
      issue(3'(CCM_OP_ABS_CALL));
      resetn = 1'b0;
      @(negedge clk);
      chk(8'(stack_bank_select), 8'(BANK_SEL_RESET));
      chk({7'h0, call_busy}, 8'h00);
      resetn = 1'b1;
      @(negedge clk);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      n_errors    = 0;
      tests_run   = 0;
      resetn      = 1'b0;
      bank_sel_we    = 1'b0;
      bank_sel_wdata = 4'h0;
      instr_valid = 1'b0;
      instr_op    = 3'h0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      t_reset_state();
      t_reg_writes();
      t_call(4'h8, 3'(CCM_OP_ABS_CALL), ABS_CYC_LEGACY);
      t_call(4'h8, 3'(CCM_OP_FAST_CALL), FAST_CYC_LEGACY);
      t_call(4'h0, 3'(CCM_OP_ABS_CALL), ABS_CYC_EXT);
      t_call(4'h0, 3'(CCM_OP_FAST_CALL), FAST_CYC_EXT);
      t_far();
      t_return(4'h8);
      t_return(4'h0);
      t_mid_reset();
      t_reset_state();
      t_call(4'h8, 3'(CCM_OP_ABS_CALL), ABS_CYC_LEGACY);
      wrap_up();
   end
endmodule
`default_nettype wire
